//--- bit_test_branch_exec.sv
// Execution sequencer for bit-test branches, set-bits and relative branches
`timescale 1ns/100ps
module bit_test_branch_exec (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  // Core side
  input wire logic START_IN,
  input wire logic [15:0] PC_IN,
  input wire logic [15:0] X_IN,
  input wire logic [15:0] Y_IN,
  input wire logic [7:0] FLAGS_IN,
  // Memory bus
  input wire logic [7:0] RDATA_IN,
  output logic [15:0] ADDR_OUT,
  output logic [7:0] WDATA_OUT,
  output logic RW_OUT,
  output logic BUS_ACTIVE_OUT,
  // Results to core
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output logic [15:0] PC_OUT,
  output logic [7:0] FLAGS_OUT,
  output logic ILLEGAL_OUT
);
  import bit_test_branch_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum {
    ST_IDLE,
    ST_OPCODE,
    ST_OPCODE2,
    ST_ADDR,
    ST_DEAD_IDX,
    ST_OPERAND,
    ST_MASK,
    ST_REL,
    ST_DEAD_END,
    ST_DEAD_WR,
    ST_WRITE
  } state_t;

  state_t state;
  state_t next_state;
  logic [15:0] op_pc;
  logic [15:0] fetch_pc;
  logic [7:0] opcode;
  logic [7:0] mem_byte;
  logic [7:0] mask;
  logic [7:0] rel;
  logic [15:0] eff_addr;
  logic [15:0] x_reg;
  logic [15:0] y_reg;
  addr_mode_t mode;
  instr_kind_t kind;
  bus_req_t bus;
  bus_req_t next_bus;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic [15:0] rel_target(input logic [15:0] base, input logic [7:0] off);
    rel_target = base + {{8{off[7]}}, off}; // [RL17]
  endfunction

  wire [7:0] op_byte = RDATA_IN;
  wire is_clr = (op_byte == OP_BCLR_DIR) || (op_byte == OP_BCLR_IDX); // [RL4]
  wire is_set = (op_byte == OP_SET_BITS_IN_MEMORY_DIR) || (op_byte == OP_SET_BITS_IN_MEMORY_IDX); // [RL5]
  wire is_setm = (op_byte == OP_SETM_DIR) || (op_byte == OP_SETM_IDX); // [RL12]
  wire is_idx_op = (op_byte == OP_BCLR_IDX) || (op_byte == OP_SET_BITS_IN_MEMORY_IDX)
                   || (op_byte == OP_SETM_IDX);
  wire is_rel = (op_byte[7:4] == 4'h2);
  wire is_prefix = (op_byte == OP_PREFIX_Y);
  wire first_legal = is_clr || is_set || is_setm || is_rel || is_prefix;
  wire second_legal = is_idx_op;
  wire instr_kind_t dec_kind = is_clr ? KIND_BCLR : is_set ? KIND_SET_BITS_IN_MEMORY :
                               is_setm ? KIND_SETM : KIND_REL;

  wire [7:0] clr_test = mem_byte & mask; // [RL1]
  wire [7:0] set_test = ~mem_byte & mask; // [RL2]
  wire bit_taken = (kind == KIND_BCLR) ? (clr_test == 8'h00) : (set_test == 8'h00);
  wire [15:0] test_step = (mode == MODE_Y) ? PC_STEP_TEST_Y : PC_STEP_TEST; // [RL3]
  wire [15:0] test_next = op_pc + test_step;
  wire [15:0] rel_next = op_pc + PC_STEP_SHORT; // [RL9]
  wire [15:0] index_base = (mode == MODE_Y) ? y_reg : x_reg;
  wire [15:0] idx_addr = index_base + {8'h00, RDATA_IN}; // [RL7]
  wire [15:0] dir_addr = {8'h00, RDATA_IN}; // [RL6]
  // Direct mode has no dead cycle, so its operand address leaves straight from the fetched byte
  wire [15:0] operand_addr = (state == ST_ADDR) ? dir_addr : eff_addr;
  wire [7:0] set_result = mem_byte | mask; // [RL11]
  wire cond_taken;
  wire cond_known;

  branch_cond_eval u_cond (
    .opcode_in(opcode),
    .flags_in(FLAGS_IN),
    .taken_out(cond_taken),
    .known_out(cond_known)
  );

  // ----------------------------------------------------------------
  // Bus address for each state
  // ----------------------------------------------------------------
  always_comb begin
    next_bus = '{addr: DEAD_ADDR, wdata: 8'h00, rw: 1'b1, active: 1'b1}; // [RL6]
    case (next_state)
      ST_OPCODE: next_bus.addr = PC_IN; // [RL6]
      ST_OPCODE2, ST_ADDR, ST_MASK, ST_REL: next_bus.addr = fetch_pc;
      ST_OPERAND: next_bus.addr = operand_addr; // [RL7]
      ST_WRITE: begin
        next_bus.addr = eff_addr; // [RL13]
        next_bus.wdata = set_result;
        next_bus.rw = 1'b0; // [RL13]
      end
      ST_IDLE: next_bus.active = 1'b0;
      default: next_bus.addr = DEAD_ADDR;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Read data answers in the cycle its address stands, so each state takes the byte it fetched;
  // the opcode fetch at PC_IN is the first bus cycle of every instruction.
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = START_IN ? ST_OPCODE : ST_IDLE;
      ST_OPCODE: begin
        if (!first_legal) next_state = ST_IDLE;
        else if (is_prefix) next_state = ST_OPCODE2;
        else if (is_rel) next_state = ST_REL;
        else next_state = ST_ADDR;
      end
      ST_OPCODE2: next_state = second_legal ? ST_ADDR : ST_IDLE;
      ST_ADDR: next_state = (mode == MODE_DIR) ? ST_OPERAND : ST_DEAD_IDX; // [RL7]
      ST_DEAD_IDX: next_state = ST_OPERAND;
      ST_OPERAND: next_state = ST_MASK;
      ST_MASK: next_state = (kind == KIND_SETM) ? ST_DEAD_WR : ST_REL;
      ST_REL: next_state = ST_DEAD_END; // [RL9]
      ST_DEAD_END: next_state = ST_IDLE;
      ST_DEAD_WR: next_state = ST_WRITE;
      ST_WRITE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      state <= ST_IDLE;
      bus <= '{addr: DEAD_ADDR, wdata: 8'h00, rw: 1'b1, active: 1'b0};
    end else begin
      state <= next_state;
      bus <= next_bus;
    end
  end

  // Operand capture
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      op_pc <= RESET_PC;
      fetch_pc <= RESET_PC;
      opcode <= 8'h00;
      mem_byte <= 8'h00;
      mask <= 8'h00;
      rel <= 8'h00;
      eff_addr <= 16'h0000;
      x_reg <= 16'h0000;
      y_reg <= 16'h0000;
      mode <= MODE_DIR;
      kind <= KIND_REL;
    end else begin
      // Advance as each program byte goes onto the bus, so fetch_pc always names the next one
      if (next_state == ST_OPCODE2 || next_state == ST_ADDR || next_state == ST_MASK
          || next_state == ST_REL) begin
        fetch_pc <= fetch_pc + 16'h0001;
      end
      case (state)
        ST_IDLE: if (START_IN) begin
          op_pc <= PC_IN;
          fetch_pc <= PC_IN + 16'h0001;
          x_reg <= X_IN;
          y_reg <= Y_IN;
        end
        ST_OPCODE: begin
          opcode <= RDATA_IN;
          kind <= dec_kind;
          mode <= is_prefix ? MODE_Y : (is_idx_op ? MODE_X : MODE_DIR);
        end
        ST_OPCODE2: begin
          opcode <= RDATA_IN;
          kind <= dec_kind;
        end
        ST_ADDR: eff_addr <= (mode == MODE_DIR) ? {8'h00, RDATA_IN} : idx_addr; // [RL6]
        ST_OPERAND: mem_byte <= RDATA_IN;
        ST_MASK: mask <= RDATA_IN;
        ST_REL: rel <= RDATA_IN;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Results
  // ----------------------------------------------------------------
  // Flags pass through untouched; none of these instructions alter them.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      DONE_OUT <= 1'b0;
      PC_OUT <= RESET_PC;
      FLAGS_OUT <= RESET_FLAGS;
      ILLEGAL_OUT <= 1'b0;
      BUSY_OUT <= 1'b0;
    end else begin
      BUSY_OUT <= (next_state != ST_IDLE);
      DONE_OUT <= 1'b0;
      ILLEGAL_OUT <= 1'b0;
      FLAGS_OUT <= FLAGS_IN; // [RL8]
      if ((state == ST_OPCODE && !first_legal) || (state == ST_OPCODE2 && !second_legal)) begin
        ILLEGAL_OUT <= 1'b1;
        DONE_OUT <= 1'b1;
        PC_OUT <= op_pc;
      end
      if (state == ST_DEAD_END) begin
        DONE_OUT <= 1'b1;
        if (kind == KIND_REL) begin
          PC_OUT <= (cond_taken && cond_known) ? rel_target(rel_next, rel) : rel_next; // [RL9]
        end else begin
          PC_OUT <= bit_taken ? rel_target(test_next, rel) : test_next; // [RL3]
        end
      end
      if (state == ST_WRITE) begin
        DONE_OUT <= 1'b1;
        PC_OUT <= fetch_pc;
      end
    end
  end

  assign ADDR_OUT = bus.addr;
  assign WDATA_OUT = bus.wdata;
  assign RW_OUT = bus.rw;
  assign BUS_ACTIVE_OUT = bus.active;

endmodule // bit_test_branch_exec

//--- bit_test_branch_pkg.sv
// Package: opcodes, bus constants, carrier types and the rule overview for the bit-test branch unit
// Overview of operation
// [RL1] Branch-if-bits-clear branches only when the tested byte ANDed with the mask is zero.
// [RL2] Branch-if-bits-set branches only when the complemented tested byte ANDed with the mask is zero.
// [RL3] A taken bit-test branch loads PC with old PC plus 4 plus offset, or plus 5 in Y-indexed form.
// [RL4] Branch-if-bits-clear is opcode 13 direct, 1f X-indexed, 18 then 1f Y-indexed; address, mask, offset follow.
// [RL5] Branch-if-bits-set is opcode 12 direct, 1e X-indexed, 18 then 1e Y-indexed; address, mask, offset follow.
// [RL6] Bit-test branches take 6, 7 and 8 read cycles; direct reads address 00dd and dead cycles drive ffff.
// [RL7] Indexed modes add the unsigned offset byte to X or Y and read the operand after one dead cycle.
// [RL8] Bit-test branches and the never-taken branch leave all condition flags unchanged.
// [RL9] The never-taken branch advances PC by 2 in three cycles: opcode, offset, dead cycle.
// [RL10] The never-taken branch is opcode 21 with one ignored offset byte.
// [RL11] Set-bits ORs the final mask byte into memory, leaving other bits unchanged.
// [RL12] Set-bits is opcode 14 direct, 1c X-indexed, 18 then 1c Y-indexed; address precedes mask.
// [RL13] Set-bits takes 6, 7 or 8 cycles and its last cycle writes the result, R/W low, to the read address.
// [RL14] Signed conditions: greater 2e, greater-equal 2c, less-equal 2f, less 2d, from Z, N and V.
// [RL15] Unsigned conditions: higher 22, lower-same 23, higher-same 24, lower 25, from C and Z.
// [RL16] Simple conditions: equal 27, not-equal 26, minus 2b, plus 2a, overflow 29 and 28, always 20.
// [RL17] The relative offset is a signed twos-complement byte added to the advanced PC.
package bit_test_branch_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_PREFIX_Y = 8'h18;
  localparam logic [7:0] OP_BCLR_DIR = 8'h13;
  localparam logic [7:0] OP_BCLR_IDX = 8'h1f;
  localparam logic [7:0] OP_SET_BITS_IN_MEMORY_DIR = 8'h12;
  localparam logic [7:0] OP_SET_BITS_IN_MEMORY_IDX = 8'h1e;
  localparam logic [7:0] OP_SETM_DIR = 8'h14;
  localparam logic [7:0] OP_SETM_IDX = 8'h1c;
  localparam logic [7:0] OP_BR_ALWAYS = 8'h20;
  localparam logic [7:0] OP_BR_NEVER = 8'h21;
  localparam logic [7:0] OP_BR_HI = 8'h22;
  localparam logic [7:0] OP_BR_LS = 8'h23;
  localparam logic [7:0] OP_BR_HS = 8'h24;
  localparam logic [7:0] OP_BR_LO = 8'h25;
  localparam logic [7:0] OP_BR_NE = 8'h26;
  localparam logic [7:0] OP_BR_EQ = 8'h27;
  localparam logic [7:0] OP_BR_VC = 8'h28;
  localparam logic [7:0] OP_BR_VS = 8'h29;
  localparam logic [7:0] OP_BR_PL = 8'h2a;
  localparam logic [7:0] OP_BR_MI = 8'h2b;
  localparam logic [7:0] OP_BR_GE = 8'h2c;
  localparam logic [7:0] OP_BR_LT = 8'h2d;
  localparam logic [7:0] OP_BR_GT = 8'h2e;
  localparam logic [7:0] OP_BR_LE = 8'h2f;

  // ----------------------------------------------------------------
  // Bus and PC constants
  // ----------------------------------------------------------------
  localparam logic [15:0] DEAD_ADDR = 16'hffff;
  localparam logic [15:0] PC_STEP_SHORT = 16'h0002;
  localparam logic [15:0] PC_STEP_TEST = 16'h0004;
  localparam logic [15:0] PC_STEP_TEST_Y = 16'h0005;
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [7:0] RESET_FLAGS = 8'h00;

  // Condition flag bit positions within FLAGS_IN
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rw;
    logic active;
  } bus_req_t;

  typedef enum logic [1:0] {
    MODE_DIR,
    MODE_X,
    MODE_Y
  } addr_mode_t;

  typedef enum logic [1:0] {
    KIND_BCLR,
    KIND_SET_BITS_IN_MEMORY,
    KIND_SETM,
    KIND_REL
  } instr_kind_t;

endpackage

//--- branch_cond_eval.sv
// Branch condition evaluator for the relative-branch opcode map
`timescale 1ns/100ps
module branch_cond_eval (
  // Opcode and flags
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] flags_in,
  // Result
  output logic taken_out,
  output logic known_out
);
  import bit_test_branch_pkg::*;

  wire c = flags_in[FLAG_C];
  wire v = flags_in[FLAG_V];
  wire z = flags_in[FLAG_Z];
  wire n = flags_in[FLAG_N];
  wire nxv = n ^ v;

  always_comb begin
    known_out = 1'b1;
    case (opcode_in)
      OP_BR_ALWAYS: taken_out = 1'b1; // [RL16]
      OP_BR_NEVER: taken_out = 1'b0; // [RL9] [RL10]
      OP_BR_HI: taken_out = ~(c | z); // [RL15]
      OP_BR_LS: taken_out = c | z; // [RL15]
      OP_BR_HS: taken_out = ~c; // [RL15]
      OP_BR_LO: taken_out = c; // [RL15]
      OP_BR_NE: taken_out = ~z; // [RL16]
      OP_BR_EQ: taken_out = z; // [RL16]
      OP_BR_VC: taken_out = ~v; // [RL16]
      OP_BR_VS: taken_out = v; // [RL16]
      OP_BR_PL: taken_out = ~n; // [RL16]
      OP_BR_MI: taken_out = n; // [RL16]
      OP_BR_GE: taken_out = ~nxv; // [RL14]
      OP_BR_LT: taken_out = nxv; // [RL14]
      OP_BR_GT: taken_out = ~(z | nxv); // [RL14]
      OP_BR_LE: taken_out = z | nxv; // [RL14]
      default: begin
        taken_out = 1'b0;
        known_out = 1'b0;
      end
    endcase
  end

endmodule // branch_cond_eval

//--- bit_test_branch_props.sv
// Checker: bus sequencing and results of the bit-test branch unit
`timescale 1ns/100ps
module bit_test_branch_props (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  // Core side
  input wire logic START_IN,
  input wire logic [15:0] PC_IN,
  input wire logic [7:0] FLAGS_IN,
  // Bus and results
  input wire logic [7:0] RDATA_IN,
  input wire logic [15:0] ADDR_OUT,
  input wire logic RW_OUT,
  input wire logic BUSY_OUT,
  input wire logic DONE_OUT,
  input wire logic [15:0] PC_OUT,
  input wire logic [7:0] FLAGS_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  // Anchored at an accepted start, so operand bytes never pass for opcodes
  sequence op_at(logic [7:0] v, logic [7:0] m);
    START_IN && !BUSY_OUT ##1 (RDATA_IN & m) == v;
  endsequence
  sequence y_at(logic [7:0] v, logic [7:0] m);
    START_IN && !BUSY_OUT ##1 RDATA_IN == 8'h18 ##1 (RDATA_IN & m) == v;
  endsequence
  fetch_next_a: assert property (START_IN && !BUSY_OUT |=>
    BUSY_OUT && RW_OUT && ADDR_OUT == $past(PC_IN)) else $error("fetch order");
  rel_dead_a: assert property (op_at(8'h20, 8'hf0) |=>
    ADDR_OUT == $past(PC_IN, 2) + 16'h0001 ##1 ADDR_OUT == 16'hffff ##1 DONE_OUT)
    else $error("relative branch timing");
  never_pc_a: assert property (op_at(8'h21, 8'hff) |-> ##3
    DONE_OUT && PC_OUT == $past(PC_IN, 4) + 16'h0002)
    else $error("never-taken branch pc");
  test_dir_a: assert property (op_at(8'h12, 8'hfe) |-> (RW_OUT && !DONE_OUT) [*6] ##1 DONE_OUT)
    else $error("direct bit test length");
  test_x_a: assert property (op_at(8'h1e, 8'hfe) |-> !DONE_OUT [*7] ##1 DONE_OUT)
    else $error("x indexed bit test length");
  test_y_a: assert property (y_at(8'h1e, 8'hfe) |-> !DONE_OUT [*7] ##1 DONE_OUT)
    else $error("y indexed bit test length");
  setm_dir_a: assert property (op_at(8'h14, 8'hff) |-> RW_OUT [*5] ##1 !RW_OUT ##1 DONE_OUT)
    else $error("direct set bits write");
  setm_x_a: assert property (op_at(8'h1c, 8'hff) |-> RW_OUT [*6] ##1 !RW_OUT ##1 DONE_OUT)
    else $error("x indexed set bits write");
  setm_y_a: assert property (y_at(8'h1c, 8'hff) |-> RW_OUT [*6] ##1 !RW_OUT ##1 DONE_OUT)
    else $error("y indexed set bits write");
  flags_kept_a: assert property (DONE_OUT |-> FLAGS_OUT == $past(FLAGS_IN))
    else $error("flags changed");
  cover property (op_at(8'h20, 8'hf0));
  cover property (y_at(8'h1c, 8'hff));
  cover property (y_at(8'h1e, 8'hfe));
endmodule // bit_test_branch_props

bind bit_test_branch_exec bit_test_branch_props i_props (
  .CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .START_IN(START_IN), .PC_IN(PC_IN),
  .FLAGS_IN(FLAGS_IN), .RDATA_IN(RDATA_IN), .ADDR_OUT(ADDR_OUT), .RW_OUT(RW_OUT),
  .BUSY_OUT(BUSY_OUT), .DONE_OUT(DONE_OUT), .PC_OUT(PC_OUT), .FLAGS_OUT(FLAGS_OUT)
);

//--- bus_memory_model.sv
// Memory on the processor bus: read data in the cycle of its address, byte writes
`timescale 1ns/100ps
module bus_memory_model
  import bit_test_branch_pkg::*;
(
  input wire logic clk_in,
  input wire bus_req_t req_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_rd;
  wire rd_now = req_in.active && req_in.rw && (req_in.addr != DEAD_ADDR);
  initial last_rd = 8'h5a;
  // Dead, idle and write cycles show the inverse of the last byte, so stale data never passes
  assign rdata_out = rd_now ? mem[req_in.addr] : ~last_rd;
  always @(posedge clk_in) begin
    last_rd <= rdata_out;
    if (req_in.active && !req_in.rw)
      mem[req_in.addr] <= req_in.wdata;
  end
endmodule // bus_memory_model

//--- bit_test_branch_exec_tb.sv
// Testbench: runs every opcode of the group against the memory model
`timescale 1ns/100ps
module bit_test_branch_exec_tb;
  import bit_test_branch_pkg::*;
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] flags;
    logic ill;
  } expect_t;
  localparam logic [7:0] DIR_OP [3] = '{OP_BCLR_DIR, OP_SET_BITS_IN_MEMORY_DIR, OP_SETM_DIR};
  localparam logic [7:0] IDX_OP [3] = '{OP_BCLR_IDX, OP_SET_BITS_IN_MEMORY_IDX, OP_SETM_IDX};
  logic clk_in, srst_in, start_in, rw_out, active_out, busy_out, done_out, ill_out;
  logic [15:0] pc_in, x_in, y_in, addr_out, pc_out, seed;
  logic [7:0] flags_in, rdata_in, wdata_out, flags_out;
  bus_req_t req;
  expect_t exp_q[$];
  int miscompares, checks_done;
  assign req = {addr_out, wdata_out, rw_out, active_out};
  bit_test_branch_exec i_dut (.CLK_IN(clk_in), .SRST_IN(srst_in), .START_IN(start_in),
    .PC_IN(pc_in), .X_IN(x_in), .Y_IN(y_in), .FLAGS_IN(flags_in), .RDATA_IN(rdata_in),
    .ADDR_OUT(addr_out), .WDATA_OUT(wdata_out), .RW_OUT(rw_out), .BUS_ACTIVE_OUT(active_out),
    .BUSY_OUT(busy_out), .DONE_OUT(done_out), .PC_OUT(pc_out), .FLAGS_OUT(flags_out),
    .ILLEGAL_OUT(ill_out));
  bus_memory_model i_mem (.clk_in(clk_in), .req_in(req), .rdata_out(rdata_in));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Flags: bit0 C, bit1 V, bit2 Z, bit3 N; odd opcodes take the complement
  function automatic logic cond_of(input logic [7:0] op, input logic [3:0] f);
    logic t;
    case (op[3:1])
      3'd0: t = 1'b1;
      3'd1: t = !(f[0] | f[2]);
      3'd2: t = !f[0];
      3'd3: t = !f[2];
      3'd4: t = !f[1];
      3'd5: t = !f[3];
      3'd6: t = !(f[3] ^ f[1]);
      default: t = !(f[2] | (f[3] ^ f[1]));
    endcase
    return t ^ op[0];
  endfunction
  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    if (exp_q.size() != 0)
      miscompares++;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic run(input logic [15:0] pc, xv, yv, input expect_t e);
    int n;
    exp_q.push_back(e);
    @(posedge clk_in);
    pc_in <= pc;
    x_in <= xv;
    y_in <= yv;
    flags_in <= e.flags;
    start_in <= 1'b1;
    @(posedge clk_in);
    start_in <= 1'b0;
    n = 0;
    while (done_out !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
  endtask
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    #50000;
    miscompares++;
    test_done();
  end
  always @(negedge clk_in) begin
    if (done_out === 1'b1 && exp_q.size() > 0) begin
      check_val("pc", exp_q[0].pc, pc_out);
      check_val("flags", {8'h00, exp_q[0].flags}, {8'h00, flags_out});
      check_val("illegal", {15'h0000, exp_q[0].ill}, {15'h0000, ill_out});
      void'(exp_q.pop_front());
    end else if (done_out === 1'b1)
      check_val("unexpected done", 16'h0000, 16'h0001);
  end
  initial begin
    int k, kind, mode, n;
    logic [7:0] op, dd, mk, rel, tb;
    logic [15:0] pc, ea, xv, yv;
    logic [39:0] code;
    expect_t e;
    srst_in = 1'b1;
    start_in = 1'b0;
    pc_in = 16'h0000;
    x_in = 16'h0000;
    y_in = 16'h0000;
    flags_in = 8'h00;
    seed = 16'hea6f;
    repeat (16) @(posedge clk_in);
    srst_in <= 1'b0;
    @(negedge clk_in);
    check_val("reset addr", DEAD_ADDR, addr_out);
    check_val("reset ctl", 16'h8000, {rw_out, active_out, busy_out, done_out, ill_out, 3'h0,
      flags_out});
    // Bit-test clear, bit-test set and set-bits, each in all three modes
    for (k = 0; k < 27; k++) begin
      kind = k % 3;
      mode = (k / 3) % 3;
      seed = lfsr(seed);
      dd = seed[7:0];
      mk = seed[15:8];
      seed = lfsr(seed);
      rel = seed[7:0];
      tb = seed[15:8];
      if (seed[0])
        tb = (kind == 0) ? (tb & ~mk) : (tb | mk);
      pc = 16'h4000 + {seed[7:0], 4'h0};
      xv = {8'h80, seed[15:8]};
      yv = {8'hc0, seed[7:0]};
      ea = (mode == 0) ? 16'h0000 : ((mode == 1) ? xv : yv);
      ea = ea + {8'h00, dd};
      op = (mode == 0) ? DIR_OP[kind] : IDX_OP[kind];
      code = (mode == 2) ? {OP_PREFIX_Y, op, dd, mk, rel} : {op, dd, mk, rel, 8'h00};
      n = 3 + (kind != 2) + (mode == 2);
      for (int i = 0; i < n; i++)
        i_mem.mem[pc + i] = code[39 - 8 * i -: 8];
      i_mem.mem[ea] = tb;
      e.ill = 1'b0;
      e.flags = seed[7:0] ^ 8'h5a;
      e.pc = ((kind == 0) ? ((tb & mk) == 8'h00) : ((~tb & mk) == 8'h00)) && kind != 2 ?
        {{8{rel[7]}}, rel} : 16'h0000;
      e.pc = e.pc + pc + n[15:0];
      run(pc, xv, yv, e);
      check_val("mem", {8'h00, (kind == 2) ? (tb | mk) : tb}, {8'h00, i_mem.mem[ea]});
    end
    // Every relative opcode against every combination of N, Z, V and C
    for (k = 0; k < 256; k++) begin
      seed = lfsr(seed);
      op = 8'h20 + k[7:4];
      pc = {4'h5, seed[11:0]};
      rel = seed[15:8];
      i_mem.mem[pc] = op;
      i_mem.mem[pc + 16'h0001] = rel;
      e.ill = 1'b0;
      e.flags = {seed[3:0], k[3:0]};
      e.pc = pc + PC_STEP_SHORT + (cond_of(op, k[3:0]) ? {{8{rel[7]}}, rel} : 16'h0000);
      run(pc, seed, ~seed, e);
    end
    // Opcodes outside the group, and a prefix with a bad second byte, come back flagged
    for (k = 0; k < 3; k++) begin
      pc = 16'h6000 + k[15:0];
      i_mem.mem[pc] = (k == 2) ? OP_PREFIX_Y : (k[0] ? 8'h15 : 8'h00);
      i_mem.mem[pc + 16'h0001] = 8'h00;
      e = '{pc: pc, flags: 8'h3c, ill: 1'b1};
      run(pc, 16'h8000, 16'hc000, e);
    end
    @(posedge clk_in);
    test_done();
  end
endmodule // bit_test_branch_exec_tb
